// [src/pmr_reset_manager.sv]
// Notes on behaviour
// - sequence fail, overtemp, supply low, software off: system reset, OFF; always-on low: system reset, BACKUP.
// - a system reset leaves the register map untouched.
// - after a system reset: reset held, OFF, no automatic restart.
// - always-on supply undervoltage sends the device to BACKUP instead of OFF.
// - supply below shutdown level, or below low threshold with OFF action: system reset.
// - writing zero to the power-on bit is a software off, a system reset.
// - start-up not finished within the allowed time is a sequence failure.
// - watchdog, external reset pin or converter undervoltage: device reset, then restart.
// - device reset returns registers to defaults, keeping interrupt status and on-source.
// - a device reset shuts down and restarts back to ON.
// - watchdog expiry counts only when its response selects device reset.
// - converter undervoltage counts only when its response selects shutdown.
// - an outside party pulling the reset line low is a device reset.
// - any write to address zero in ON is a software reset: shutdown then back to ON.
// - the map-keep field decides whether a software reset clears registers.
// - supply under the power-on threshold forces NO POWER, registers lost, no recovery.
// - after automatic recovery the cause is readable in the on-source register.
// - recurring watchdog or converter faults: at most seven start-ups, then stay OFF.
// - reset line low from shutdown start and in OFF; released once start-up completes.
//
// Chosen here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module pmr_reset_manager
	import pmr_pkg::*;
#(
	parameter int unsigned STARTUP_TIMEOUT_CYC = STARTUP_TIMEOUT_CYC_DEF
) (
	// clock, reset, enable
	input wire logic CLK_IN,
	input wire logic RESETN_IN,
	input wire logic CE_IN,
	// register port
	input wire logic [ADDR_W-1:0] ADDR_IN,
	input wire logic [DATA_W-1:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [DATA_W-1:0] RDATA_OUT,
	// supply and fault monitors
	input wire logic POR_IN,
	input wire logic AON_SUPPLY_LOW_IN,
	input wire logic SYS_BELOW_SHUTDOWN_IN,
	input wire logic SYS_BELOW_LOW_THR_IN,
	input wire logic OVERTEMP_IN,
	input wire logic WDOG_EXPIRED_IN,
	input wire logic [NUM_CONV-1:0] CONV_UV_IN,
	// power sequencing
	input wire logic ON_EVENT_IN,
	input wire logic STARTUP_OK_IN,
	output logic RAIL_ENABLE_OUT,
	output logic REG_MAP_CLEAR_OUT,
	output logic [2:0] POWER_STATE_OUT,
	output logic [THR_W-1:0] SYS_LOW_THR_OUT,
	// open-drain reset line to the host
	input wire logic RST_PIN_IN,
	output logic RST_PIN_OUT,
	output logic RST_PIN_OE_N_OUT,
	// interrupt
	output logic IRQ_OUT
);

	pmr_state_type state_q, state_d;
	pmr_cause_type cause_q, cause_d, on_src_q, on_src_d, cls_cause;
	logic auto_q, auto_d, backup_q, backup_d, counted_q, counted_d;
	logic [31:0] tmr_q, tmr_d;
	logic [2:0] att_q, att_d;
	logic rst_n_q, rst_n_d, rail_q, rail_d, clear_q, clear_d;
	logic [NUM_EVT-1:0] evt;
	logic start_done;
	logic pwr_on_q, pwr_on_d, keep_q, keep_d, low_act_q, low_act_d, wdog_dev_q, wdog_dev_d;
	logic [NUM_CONV-1:0] conv_act_q, conv_act_d;
	logic [THR_W-1:0] thr_q, thr_d;
	logic [NUM_EVT-1:0] stat_q, stat_d, mask_q, mask_d;
	logic irq_q, irq_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic sys_req, dev_req, sw_req, counted, seq_fail, hw_rst, take;

	// one decode, used by both the fsm and the register file
	function automatic logic is_wr(input logic [ADDR_W-1:0] a);
		return WR_IN && (ADDR_IN == a);
	endfunction

	// the pin is only judged while we leave it alone, so our own drive never self-triggers
	assign hw_rst = rst_n_q && !RST_PIN_IN;
	assign seq_fail = (state_q == PST_STARTUP) && !STARTUP_OK_IN &&
		(tmr_q == 32'(STARTUP_TIMEOUT_CYC - 1));

	pmr_reset_classifier u_cls (
		.seq_fail_in(seq_fail),
		.overtemp_in(OVERTEMP_IN),
		.sys_shutdown_in(SYS_BELOW_SHUTDOWN_IN),
		.sys_low_in(SYS_BELOW_LOW_THR_IN),
		.low_act_off_in(low_act_q),
		.sw_off_in(is_wr(REG_PWR_CTRL) && !WDATA_IN[PC_PWR_ON_BIT]),
		.aon_low_in(AON_SUPPLY_LOW_IN),
		.wdog_in(WDOG_EXPIRED_IN),
		.wdog_dev_in(wdog_dev_q),
		.hw_rst_in(hw_rst),
		.conv_uv_in(CONV_UV_IN),
		.conv_act_in(conv_act_q),
		.sw_rst_in(is_wr(REG_SW_RESET)),
		.sys_req_out(sys_req),
		.dev_req_out(dev_req),
		.sw_req_out(sw_req),
		.counted_out(counted),
		.cause_out(cls_cause)
	);

	// software resets only count in ON; start-up can still fail or see a fault
	assign take = (state_q == PST_ON && (sys_req || dev_req || sw_req)) ||
		(state_q == PST_STARTUP && (sys_req || dev_req));

	// power state sequencing
	always_comb begin
		state_d = state_q;
		cause_d = cause_q;
		on_src_d = on_src_q;
		auto_d = auto_q;
		backup_d = backup_q;
		counted_d = counted_q;
		tmr_d = tmr_q;
		att_d = att_q;
		rst_n_d = rst_n_q;
		rail_d = rail_q;
		clear_d = 1'b0;
		evt = '0;
		start_done = 1'b0;
		if (POR_IN) begin
			state_d = PST_NOPOWER;
			rst_n_d = 1'b0;
			rail_d = 1'b0;
			auto_d = 1'b0;
			clear_d = 1'b1;
		end else if (take) begin
			state_d = PST_SHUTDOWN;
			tmr_d = '0;
			rst_n_d = 1'b0;
			cause_d = cls_cause;
			counted_d = counted;
			auto_d = dev_req || sw_req;
			backup_d = sys_req && AON_SUPPLY_LOW_IN;
			clear_d = dev_req || (sw_req && !keep_q);
			evt[EVT_SYS] = sys_req;
			evt[EVT_DEV] = dev_req;
			evt[EVT_SW] = sw_req;
		end else begin
			unique case (state_q)
				PST_ON: begin
					rst_n_d = 1'b1;
				end
				PST_SHUTDOWN: begin
					rail_d = 1'b0;
					if (tmr_q == SHUTDOWN_CYC - 32'h1) begin
						tmr_d = '0;
						if (backup_q) begin
							state_d = PST_BACKUP;
						end else if (!auto_q) begin
							state_d = PST_OFF;
						end else if (counted_q && att_q == MAX_ATTEMPTS) begin
							state_d = PST_OFF;
							evt[EVT_RETRY_LIM] = 1'b1;
						end else begin
							state_d = PST_STARTUP;
							rail_d = 1'b1;
							if (counted_q) begin
								att_d = att_q + 3'h1;
							end
						end
					end else begin
						tmr_d = tmr_q + 32'h1;
					end
				end
				PST_OFF: begin
					if (AON_SUPPLY_LOW_IN) begin
						state_d = PST_BACKUP;
					end else if (ON_EVENT_IN) begin
						state_d = PST_STARTUP;
						rail_d = 1'b1;
						tmr_d = '0;
						att_d = '0;
						auto_d = 1'b0;
					end
				end
				PST_STARTUP: begin
					if (STARTUP_OK_IN) begin
						state_d = PST_ON;
						rst_n_d = 1'b1;
						start_done = 1'b1;
						if (auto_q) begin
							on_src_d = cause_q;
							evt[EVT_RECOVER] = 1'b1;
						end
					end else begin
						tmr_d = tmr_q + 32'h1;
					end
				end
				PST_BACKUP: begin
					if (!AON_SUPPLY_LOW_IN) begin
						state_d = PST_OFF;
					end
				end
				PST_NOPOWER: begin
					state_d = PST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			state_q <= PST_OFF;
			cause_q <= CAUSE_NONE;
			on_src_q <= CAUSE_NONE;
			auto_q <= 1'b0;
			backup_q <= 1'b0;
			counted_q <= 1'b0;
			tmr_q <= '0;
			att_q <= '0;
			rst_n_q <= 1'b0;
			rail_q <= 1'b0;
			clear_q <= 1'b0;
		end else if (CE_IN) begin
			state_q <= state_d;
			cause_q <= cause_d;
			on_src_q <= on_src_d;
			auto_q <= auto_d;
			backup_q <= backup_d;
			counted_q <= counted_d;
			tmr_q <= tmr_d;
			att_q <= att_d;
			rst_n_q <= rst_n_d;
			rail_q <= rail_d;
			clear_q <= clear_d;
		end
	end

	// register file; status and on-source survive a map clear so software can see why
	always_comb begin
		pwr_on_d = pwr_on_q;
		keep_d = keep_q;
		low_act_d = low_act_q;
		wdog_dev_d = wdog_dev_q;
		conv_act_d = conv_act_q;
		thr_d = thr_q;
		mask_d = mask_q;
		stat_d = stat_q;
		rdata_d = '0;
		if (clear_d) begin
			pwr_on_d = PWR_ON_RST;
			keep_d = MAP_KEEP_RST;
			low_act_d = LOW_ACT_RST;
			wdog_dev_d = WDOG_DEV_RST;
			conv_act_d = CONV_ACT_RST;
			thr_d = SYS_LOW_THR_RST;
			mask_d = IRQ_MASK_RST;
		end else begin
			if (is_wr(REG_PWR_CTRL)) begin
				pwr_on_d = WDATA_IN[PC_PWR_ON_BIT];
				keep_d = WDATA_IN[PC_MAP_KEEP_BIT];
				low_act_d = WDATA_IN[PC_LOW_ACT_BIT];
				wdog_dev_d = WDATA_IN[PC_WDOG_DEV_BIT];
			end
			if (is_wr(REG_CONV_UV_ACT)) begin
				conv_act_d = WDATA_IN[NUM_CONV-1:0];
			end
			if (is_wr(REG_SYS_LOW_THR)) begin
				thr_d = WDATA_IN[THR_W-1:0];
			end
			if (is_wr(REG_IRQ_MASK)) begin
				mask_d = WDATA_IN[NUM_EVT-1:0];
			end
			if (start_done) begin
				pwr_on_d = 1'b1;
			end
		end
		// a new event wins over a write-one clear in the same cycle
		if (is_wr(REG_IRQ_STATUS)) begin
			stat_d = stat_q & ~WDATA_IN[NUM_EVT-1:0];
		end
		stat_d = stat_d | evt;
		irq_d = |(stat_q & ~mask_q);
		if (RD_IN) begin
			unique case (ADDR_IN)
				REG_PWR_CTRL: begin
					rdata_d[PC_PWR_ON_BIT] = pwr_on_q;
					rdata_d[PC_MAP_KEEP_BIT] = keep_q;
					rdata_d[PC_LOW_ACT_BIT] = low_act_q;
					rdata_d[PC_WDOG_DEV_BIT] = wdog_dev_q;
				end
				REG_CONV_UV_ACT: rdata_d[NUM_CONV-1:0] = conv_act_q;
				REG_ON_SOURCE: begin
					rdata_d[OS_CAUSE_LSB +: 4] = on_src_q;
					rdata_d[OS_ATT_LSB +: 3] = att_q;
					rdata_d[OS_STATE_LSB +: 3] = state_q;
				end
				REG_IRQ_STATUS: rdata_d[NUM_EVT-1:0] = stat_q;
				REG_IRQ_MASK: rdata_d[NUM_EVT-1:0] = mask_q;
				REG_SYS_LOW_THR: rdata_d[THR_W-1:0] = thr_q;
				default: rdata_d = '0; // unmapped and write-only read as zero
			endcase
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RESETN_IN) begin
			pwr_on_q <= PWR_ON_RST;
			keep_q <= MAP_KEEP_RST;
			low_act_q <= LOW_ACT_RST;
			wdog_dev_q <= WDOG_DEV_RST;
			conv_act_q <= CONV_ACT_RST;
			thr_q <= SYS_LOW_THR_RST;
			mask_q <= IRQ_MASK_RST;
			stat_q <= '0;
			irq_q <= 1'b0;
			rdata_q <= '0;
		end else if (CE_IN) begin
			pwr_on_q <= pwr_on_d;
			keep_q <= keep_d;
			low_act_q <= low_act_d;
			wdog_dev_q <= wdog_dev_d;
			conv_act_q <= conv_act_d;
			thr_q <= thr_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	// outputs straight from flops
	assign RDATA_OUT = rdata_q;
	assign RAIL_ENABLE_OUT = rail_q;
	assign REG_MAP_CLEAR_OUT = clear_q;
	assign POWER_STATE_OUT = state_q;
	assign SYS_LOW_THR_OUT = thr_q;
	assign RST_PIN_OUT = rst_n_q; // open drain: value only matters while enabled
	assign RST_PIN_OE_N_OUT = rst_n_q;
	assign IRQ_OUT = irq_q;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RESETN_IN);

	sequence s_take_sys;
		CE_IN && !POR_IN && take && sys_req;
	endsequence
	sequence s_take_dev;
		CE_IN && !POR_IN && take && dev_req;
	endsequence

	chk_sys_no_restart: assert property (s_take_sys |=> state_q == PST_SHUTDOWN && !auto_q)
		else $error("system reset scheduled a restart");
	chk_sys_keeps_map: assert property (s_take_sys |=> !clear_q)
		else $error("system reset cleared the map");
	// end of the shutdown count with nothing overriding it
	sequence s_shut_end;
		CE_IN && !POR_IN && !take && state_q == PST_SHUTDOWN && tmr_q == SHUTDOWN_CYC - 32'h1;
	endsequence

	chk_backup_flag: assert property (s_take_sys ##0 AON_SUPPLY_LOW_IN |=> backup_q)
		else $error("always-on undervoltage not remembered");
	chk_backup_target: assert property (s_shut_end ##0 backup_q |=> state_q == PST_BACKUP)
		else $error("always-on undervoltage did not reach backup");
	chk_dev_clears_map: assert property (s_take_dev |=> clear_q && auto_q && !rst_n_q)
		else $error("device reset did not clear map or restart");
	chk_sw_reset: assert property (
		CE_IN && !POR_IN && state_q == PST_ON && sw_req |=>
		cause_q == CAUSE_SW_RST && auto_q && clear_q == !$past(keep_q))
		else $error("software reset handled wrongly");
	chk_por_nopower: assert property (CE_IN && POR_IN |=> state_q == PST_NOPOWER && clear_q)
		else $error("power-on reset missed no-power state");
	chk_attempt_limit: assert property (
		CE_IN && state_q == PST_SHUTDOWN && tmr_q == SHUTDOWN_CYC - 32'h1 && !POR_IN && !take
		&& !backup_q && auto_q && counted_q && att_q == MAX_ATTEMPTS |=> state_q == PST_OFF)
		else $error("start-up tried beyond seven attempts");
	chk_on_source: assert property (
		CE_IN && !POR_IN && !take && state_q == PST_STARTUP && STARTUP_OK_IN && auto_q
		|=> on_src_q == $past(cause_q) && state_q == PST_ON)
		else $error("on-source not recorded");
	chk_reset_line: assert property (state_q != PST_ON |-> !rst_n_q)
		else $error("reset line released outside on state");
	chk_startup_timeout: assert property (
		CE_IN && !POR_IN && seq_fail |=> state_q == PST_SHUTDOWN && cause_q == CAUSE_SEQ_FAIL)
		else $error("start-up timeout not flagged");

endmodule
`default_nettype wire

// [src/pmr_pkg.sv]
package pmr_pkg;

	// register bus shape
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;

	// register offsets
	localparam logic [15:0] REG_SW_RESET = 16'h0000;
	localparam logic [15:0] REG_PWR_CTRL = 16'h0001;
	localparam logic [15:0] REG_CONV_UV_ACT = 16'h0002;
	localparam logic [15:0] REG_ON_SOURCE = 16'h0003;
	localparam logic [15:0] REG_IRQ_STATUS = 16'h0004;
	localparam logic [15:0] REG_IRQ_MASK = 16'h0005;
	localparam logic [15:0] REG_SYS_LOW_THR = 16'h0006;

	// power control fields
	localparam int PC_PWR_ON_BIT = 0;
	localparam int PC_MAP_KEEP_BIT = 1;
	localparam int PC_LOW_ACT_BIT = 2;
	localparam int PC_WDOG_DEV_BIT = 3;
	localparam logic PWR_ON_RST = 1'b0;
	localparam logic MAP_KEEP_RST = 1'b1;
	localparam logic LOW_ACT_RST = 1'b0;
	localparam logic WDOG_DEV_RST = 1'b1;

	// converter undervoltage response, one bit per converter
	localparam int NUM_CONV = 14;
	localparam logic [NUM_CONV-1:0] CONV_ACT_RST = 14'h0000;

	// low threshold for the system supply comparator
	localparam int THR_W = 8;
	localparam logic [THR_W-1:0] SYS_LOW_THR_RST = 8'h80;

	// on-source register layout
	localparam int OS_CAUSE_LSB = 0;
	localparam int OS_ATT_LSB = 4;
	localparam int OS_STATE_LSB = 8;

	// interrupt events
	localparam int NUM_EVT = 5;
	localparam int EVT_SYS = 0;
	localparam int EVT_DEV = 1;
	localparam int EVT_SW = 2;
	localparam int EVT_RECOVER = 3;
	localparam int EVT_RETRY_LIM = 4;
	localparam logic [NUM_EVT-1:0] IRQ_MASK_RST = 5'h1f;

	// start-up attempts allowed for recurring faults
	localparam logic [2:0] MAX_ATTEMPTS = 3'h7;

	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SHUTDOWN_TIME_NS = 20000;
	localparam logic [31:0] SHUTDOWN_CYC =
		32'((SHUTDOWN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int STARTUP_TIMEOUT_US = 2000;
	localparam int STARTUP_TIMEOUT_CYC_DEF = STARTUP_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		PST_ON, PST_SHUTDOWN, PST_OFF, PST_STARTUP, PST_BACKUP, PST_NOPOWER
	} pmr_state_type;

	typedef enum logic [3:0] {
		CAUSE_NONE, CAUSE_SEQ_FAIL, CAUSE_OVERTEMP, CAUSE_SYS_SHUTDOWN, CAUSE_SYS_LOW,
		CAUSE_SW_OFF, CAUSE_AON_LOW, CAUSE_WDOG, CAUSE_HW_RST, CAUSE_CONV_UV, CAUSE_SW_RST
	} pmr_cause_type;

endpackage

// [src/pmr_reset_classifier.sv]
`timescale 1ns/1ns
`default_nettype none
module pmr_reset_classifier
	import pmr_pkg::*;
(
	// system reset conditions
	input wire logic seq_fail_in,
	input wire logic overtemp_in,
	input wire logic sys_shutdown_in,
	input wire logic sys_low_in,
	input wire logic low_act_off_in,
	input wire logic sw_off_in,
	input wire logic aon_low_in,
	// device reset conditions
	input wire logic wdog_in,
	input wire logic wdog_dev_in,
	input wire logic hw_rst_in,
	input wire logic [NUM_CONV-1:0] conv_uv_in,
	input wire logic [NUM_CONV-1:0] conv_act_in,
	// software reset
	input wire logic sw_rst_in,
	// class and cause
	output logic sys_req_out,
	output logic dev_req_out,
	output logic sw_req_out,
	output logic counted_out,
	output pmr_cause_type cause_out
);

	// priority: system over device over software
	always_comb begin
		sys_req_out = 1'b0;
		dev_req_out = 1'b0;
		sw_req_out = 1'b0;
		counted_out = 1'b0;
		cause_out = CAUSE_NONE;
		if (seq_fail_in) begin
			sys_req_out = 1'b1;
			cause_out = CAUSE_SEQ_FAIL;
		end else if (overtemp_in) begin
			sys_req_out = 1'b1;
			cause_out = CAUSE_OVERTEMP;
		end else if (sys_shutdown_in) begin
			sys_req_out = 1'b1;
			cause_out = CAUSE_SYS_SHUTDOWN;
		end else if (sys_low_in && low_act_off_in) begin
			sys_req_out = 1'b1;
			cause_out = CAUSE_SYS_LOW;
		end else if (sw_off_in) begin
			sys_req_out = 1'b1;
			cause_out = CAUSE_SW_OFF;
		end else if (aon_low_in) begin
			sys_req_out = 1'b1;
			cause_out = CAUSE_AON_LOW;
		end else if (wdog_in && wdog_dev_in) begin
			dev_req_out = 1'b1;
			counted_out = 1'b1;
			cause_out = CAUSE_WDOG;
		end else if (hw_rst_in) begin
			dev_req_out = 1'b1;
			cause_out = CAUSE_HW_RST;
		end else if (|(conv_uv_in & conv_act_in)) begin
			dev_req_out = 1'b1;
			counted_out = 1'b1;
			cause_out = CAUSE_CONV_UV;
		end else if (sw_rst_in) begin
			sw_req_out = 1'b1;
			cause_out = CAUSE_SW_RST;
		end
	end

endmodule
`default_nettype wire

// [verification/pmr_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module pmr_host_model (
	// device drive and host request
	input wire logic oe_n_in,
	input wire logic pull_in,
	// resolved wire level
	output logic wire_out
);
	// open-drain wire with a pull-up: low if either party pulls it
	assign wire_out = (oe_n_in && !pull_in) ? 1'b1 : 1'b0;
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import pmr_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic por = 1'b0, aon = 1'b0, shut = 1'b0, low = 1'b0, hot = 1'b0, wdog = 1'b0;
	logic on_ev = 1'b0, up_ok = 1'b1, pull = 1'b0;
	logic [NUM_CONV-1:0] uv = '0;
	logic [15:0] rdata;
	logic [15:0] v;
	logic rail, clr, irq, pin_o, oe_n, pin_w;
	logic [2:0] st;
	logic [THR_W-1:0] thr;
	int errors = 0, samples_checked = 0, clr_cnt = 0, c0;

	// 100 mhz clock
	always #5 clk = ~clk;
	// count map-clear pulses, since each lasts one cycle only
	always @(posedge clk) if (clr === 1'b1) clr_cnt <= clr_cnt + 1;

	// short startup timeout keeps the run brief
	pmr_reset_manager #(.STARTUP_TIMEOUT_CYC(50)) uut (
		.CLK_IN(clk), .RESETN_IN(rst_n), .CE_IN(1'b1),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.POR_IN(por), .AON_SUPPLY_LOW_IN(aon), .SYS_BELOW_SHUTDOWN_IN(shut),
		.SYS_BELOW_LOW_THR_IN(low), .OVERTEMP_IN(hot), .WDOG_EXPIRED_IN(wdog),
		.CONV_UV_IN(uv), .ON_EVENT_IN(on_ev), .STARTUP_OK_IN(up_ok),
		.RAIL_ENABLE_OUT(rail), .REG_MAP_CLEAR_OUT(clr), .POWER_STATE_OUT(st),
		.SYS_LOW_THR_OUT(thr), .RST_PIN_IN(pin_w), .RST_PIN_OUT(pin_o),
		.RST_PIN_OE_N_OUT(oe_n), .IRQ_OUT(irq)
	);
	// host processor on the reset wire
	pmr_host_model host (.oe_n_in(oe_n), .pull_in(pull), .wire_out(pin_w));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// bounded wait for a power state, then compare
	task automatic wait_st(input logic [2:0] s, input int n);
		int i;
		i = 0;
		while (st !== s && i < n) begin
			@(posedge clk);
			#1 i++;
		end
		chk(16'(st), 16'(s));
	endtask
	task automatic cause_is(input logic [15:0] c);
		rd_reg(REG_ON_SOURCE, v);
		chk(16'(v[3:0]), c);
	endtask
	task automatic kick_on();
		@(posedge clk);
		on_ev <= 1'b1;
		@(posedge clk);
		on_ev <= 1'b0;
	endtask
	task automatic go_on();
		kick_on();
		wait_st(PST_ON, 20);
		chk(16'(oe_n), 16'h0001);
	endtask
	task automatic pulse_wdog();
		@(posedge clk);
		wdog <= 1'b1;
		@(posedge clk);
		wdog <= 1'b0;
	endtask
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// watchdog: the tests need about 40000 cycles
	initial begin
		#(700_000);
		errors++;
		report_and_stop();
	end

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		settle(1);
		wait_st(PST_OFF, 0);
		chk(16'(oe_n), 16'h0000);
		chk(16'(thr), 16'h0080);
		rd_reg(REG_PWR_CTRL, v);
		chk(v, 16'h000a);
		rd_reg(REG_IRQ_MASK, v);
		chk(v, 16'h001f);
		rd_reg(16'h0007, v);
		chk(v, 16'h0000);
		done("defaults");

		// expiry ignored while its response is not device reset
		go_on();
		wr_reg(REG_PWR_CTRL, 16'h0003);
		pulse_wdog();
		settle(4);
		wait_st(PST_ON, 0);
		done("wdog_off");

		// every system reset cause except sequence failure: no restart, map untouched
		wr_reg(REG_SYS_LOW_THR, 16'h0033);
		for (int k = 0; k < 5; k++) begin
			c0 = clr_cnt;
			go_on();
			@(posedge clk);
			case (k)
				0: hot <= 1'b1;
				1: shut <= 1'b1;
				2: low <= 1'b1;
				3: ;
				default: aon <= 1'b1;
			endcase
			if (k == 2) begin
				settle(4);
				wait_st(PST_ON, 0);
				wr_reg(REG_PWR_CTRL, 16'h0007);
			end
			if (k == 3) wr_reg(REG_PWR_CTRL, 16'h000e);
			wait_st(PST_SHUTDOWN, 3);
			chk(16'(oe_n), 16'h0000);
			hot <= 1'b0;
			shut <= 1'b0;
			low <= 1'b0;
			wait_st((k == 4) ? PST_BACKUP : PST_OFF, 2100);
			settle(20);
			wait_st((k == 4) ? PST_BACKUP : PST_OFF, 0);
			chk(16'(thr), 16'h0033);
			chk(16'(clr_cnt - c0), 16'h0000);
		end
		@(posedge clk);
		por <= 1'b1;
		wait_st(PST_NOPOWER, 3);
		aon <= 1'b0;
		por <= 1'b0;
		wait_st(PST_OFF, 3);
		chk(16'(thr), 16'h0080);
		settle(10);
		wait_st(PST_OFF, 0);
		done("system");

		// watchdog device reset clears the map and restarts
		go_on();
		wr_reg(REG_SYS_LOW_THR, 16'h0033);
		wr_reg(REG_IRQ_MASK, 16'h0000);
		c0 = clr_cnt;
		pulse_wdog();
		wait_st(PST_SHUTDOWN, 3);
		wait_st(PST_STARTUP, 2100);
		wait_st(PST_ON, 20);
		chk(16'(clr_cnt - c0), 16'h0001);
		chk(16'(thr), 16'h0080);
		rd_reg(REG_IRQ_MASK, v);
		chk(v, 16'h001f);
		cause_is(16'h0007);
		done("device");

		// software reset with the map kept, then interrupt handling
		wr_reg(REG_IRQ_STATUS, 16'h001f);
		wr_reg(REG_IRQ_MASK, 16'h0000);
		c0 = clr_cnt;
		wr_reg(REG_SW_RESET, 16'h1234);
		wait_st(PST_SHUTDOWN, 3);
		wait_st(PST_ON, 2120);
		chk(16'(clr_cnt - c0), 16'h0000);
		cause_is(16'h000a);
		rd_reg(REG_IRQ_STATUS, v);
		chk(16'(v[EVT_SW]), 16'h0001);
		chk(16'(irq), 16'h0001);
		wr_reg(REG_IRQ_MASK, 16'h001f);
		settle(2);
		chk(16'(irq), 16'h0000);
		wr_reg(REG_IRQ_MASK, 16'h0000);
		wr_reg(REG_IRQ_STATUS, 16'h001f);
		settle(2);
		chk(16'(irq), 16'h0000);
		// map not kept this time
		wr_reg(REG_PWR_CTRL, 16'h0009);
		c0 = clr_cnt;
		wr_reg(REG_SW_RESET, 16'h0000);
		wait_st(PST_SHUTDOWN, 3);
		wait_st(PST_ON, 2120);
		chk(16'(clr_cnt - c0), 16'h0001);
		done("software");

		// host pulls the reset wire
		c0 = clr_cnt;
		@(posedge clk);
		pull <= 1'b1;
		wait_st(PST_SHUTDOWN, 6);
		pull <= 1'b0;
		wait_st(PST_ON, 2120);
		chk(16'(clr_cnt - c0), 16'h0001);
		cause_is(16'h0008);
		done("hardware");

		// converter undervoltage acts only when selected
		@(posedge clk);
		uv <= 14'h0001;
		settle(4);
		wait_st(PST_ON, 0);
		wr_reg(REG_CONV_UV_ACT, 16'h0001);
		wait_st(PST_SHUTDOWN, 3);
		uv <= '0;
		wait_st(PST_ON, 2120);
		cause_is(16'h0009);
		done("converter");

		// start-up never completes
		wr_reg(REG_PWR_CTRL, 16'h000a);
		wait_st(PST_OFF, 2100);
		up_ok <= 1'b0;
		kick_on();
		wait_st(PST_STARTUP, 3);
		wait_st(PST_SHUTDOWN, 60);
		up_ok <= 1'b1;
		wait_st(PST_OFF, 2100);
		done("timeout");

		// persistent watchdog: bounded attempts, then stay off
		go_on();
		@(posedge clk);
		wdog <= 1'b1;
		wait_st(PST_OFF, 20000);
		settle(100);
		wait_st(PST_OFF, 0);
		wdog <= 1'b0;
		go_on();
		done("retry");
		report_and_stop();
	end
endmodule
`default_nettype wire
